// [fsg_pkg.sv]
// constants, field layouts and carrier types of the frequent start guard
// assumes a single 50 MHz clock domain and a plain strobe register port
// Function
// - Motor counts as hot when used thermal capacity exceeds hot limit, default 70.0%.
// - Cold safe stall time, default 20.0 s; zero means use the hot stall time.
// - Hot safe stall time, default 15.0 s, used while the motor is hot.
// - Allowed starts per window for a cold motor, default three.
// - Allowed starts per window for a hot motor, default two.
// - Start window length in whole hours, default one hour.
// - Minimum interval between starts, 0.1 s steps, default 20.0 s.
// - Alarm while exactly one start remains available.
// - Restart inhibit when all starts used, held until one start is available.
// - Blocked output while enabled and the blocking input is active.
// - One ON and one OFF event per edge of alarm, inhibit and blocked.
// - Twelve newest time-stamped records with inhibit time, since-start and starts used.
// - Motor data settings kept in one store shared with other functions.
// - Hot/cold separation only while thermal overload function supplies capacity.
// - Each start adds stall time; counter decays at stall time times allowed starts per window.
// - Inhibit also when a start follows the previous sooner than minimum interval.
// - Condition code: 0 normal, 1 start, 2 trip, 3 blocked.
package fsg_pkg;

    // ======================================================================
    // timing
    localparam int unsigned CLK_HZ       = 50_000_000;
    localparam int unsigned TICK_MS      = 1;
    localparam int unsigned MS_CYC_DEF   = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned DS_MS        = 100;
    localparam int unsigned HOUR_DS      = 36000;

    // ======================================================================
    // register byte offsets
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_HOT_LIM   = 8'h04;
    localparam logic [7:0] OFS_STALL_C   = 8'h08;
    localparam logic [7:0] OFS_STALL_H   = 8'h0C;
    localparam logic [7:0] OFS_STARTS_C  = 8'h10;
    localparam logic [7:0] OFS_STARTS_H  = 8'h14;
    localparam logic [7:0] OFS_WINDOW    = 8'h18;
    localparam logic [7:0] OFS_MIN_INT   = 8'h1C;
    localparam logic [7:0] OFS_STATUS    = 8'h20;
    localparam logic [7:0] OFS_IRQ_STS   = 8'h24;
    localparam logic [7:0] OFS_IRQ_MSK   = 8'h28;
    localparam logic [7:0] OFS_LOG_SEL   = 8'h2C;
    localparam logic [7:0] OFS_LOG_TSL   = 8'h30;
    localparam logic [7:0] OFS_LOG_TSH   = 8'h34;
    localparam logic [7:0] OFS_LOG_EVT   = 8'h38;
    localparam logic [7:0] OFS_LOG_INH   = 8'h3C;
    localparam logic [7:0] OFS_LOG_SINCE = 8'h40;

    // ======================================================================
    // reset values
    localparam logic        RST_ENABLE   = 1'b0;
    localparam logic [9:0]  RST_HOT_LIM  = 10'h2BC;
    localparam logic [12:0] RST_STALL_C  = 13'h00C8;
    localparam logic [12:0] RST_STALL_H  = 13'h0096;
    localparam logic [6:0]  RST_STARTS_C = 7'h03;
    localparam logic [6:0]  RST_STARTS_H = 7'h02;
    localparam logic [6:0]  RST_WINDOW   = 7'h01;
    localparam logic [12:0] RST_MIN_INT  = 13'h00C8;

    // ======================================================================
    // status field positions
    localparam int ST_ALARM   = 0;
    localparam int ST_INHIBIT = 1;
    localparam int ST_BLOCKED = 2;
    localparam int ST_COND    = 3;
    localparam int ST_HOT     = 5;
    localparam int ST_USED    = 8;

    localparam int LOG_DEPTH  = 12;
    localparam int NUM_EVT    = 6;

    typedef enum logic [1:0] {
        FSG_COND_NORMAL  = 2'b00,
        FSG_COND_START   = 2'b01,
        FSG_COND_TRIP    = 2'b10,
        FSG_COND_BLOCKED = 2'b11
    } fsg_cond_t;

    // event codes: bit pairs ON/OFF per output
    typedef enum logic [2:0] {
        FSG_EV_ALARM_ON   = 3'b000,
        FSG_EV_ALARM_OFF  = 3'b001,
        FSG_EV_INHIBIT_ON = 3'b010,
        FSG_EV_INHIBIT_OFF= 3'b011,
        FSG_EV_BLOCKED_ON = 3'b100,
        FSG_EV_BLOCKED_OFF= 3'b101
    } fsg_evt_t;

    typedef struct packed {
        logic [9:0]  hot_limit;
        logic [12:0] stall_cold;
        logic [12:0] stall_hot;
        logic [6:0]  starts_cold;
        logic [6:0]  starts_hot;
        logic [6:0]  window_h;
        logic [12:0] min_interval;
    } fsg_cfg_t;

    typedef struct packed {
        logic [47:0] ts_ms;
        logic [2:0]  evt;
        logic [7:0]  used;
        logic [23:0] inh_ds;
        logic [23:0] since_ds;
    } fsg_rec_t;

endpackage

// [fsg_log_mem.sv]
// twelve-entry record store for the start guard log
// assumes one write and one registered read per clock
`timescale 1ns/1ps
`default_nettype none
module fsg_log_mem
    import fsg_pkg::*;
(
    // clock
    input  wire logic     clk,
    // write side
    input  wire logic     we,
    input  wire logic [3:0] waddr,
    input  wire fsg_rec_t wdata,
    // read side
    input  wire logic [3:0] raddr,
    output fsg_rec_t      rdata
);
    fsg_rec_t mem [LOG_DEPTH];
    fsg_rec_t rdata_ff;

    // no reset: contents are only valid up to the fill count
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata_ff <= mem[raddr];
    end

    assign rdata = rdata_ff;
endmodule
`default_nettype wire

// [fsg_top.sv]
// frequent start guard: start stress counter, alarm, inhibit, events, log
// assumes motor status and thermal inputs come from logic on clk
`timescale 1ns/1ps
`default_nettype none
module fsg_top
    import fsg_pkg::*;
#(
    parameter int unsigned MS_CYCLES = MS_CYC_DEF
)(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // register port
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic [31:0]      rdata,
    // motor and thermal status
    input  wire logic        motor_start_detected,
    input  wire logic        block_in,
    input  wire logic        thermal_active,
    input  wire logic [9:0]  theta_pm,
    // protection outputs
    output logic             alarm,
    output logic             inhibit,
    output logic             blocked,
    output fsg_cond_t        condition,
    output logic [5:0]       start_guard_event_block,
    output logic             irq,
    // shared motor data
    output fsg_cfg_t         motor_cfg
);
    // ======================================================================
    // helpers
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    function automatic logic [3:0] log_phys(input logic [3:0] wp, input logic [3:0] sel);
        logic [4:0] t;
        t = 5'(wp) + 5'(LOG_DEPTH - 1) - 5'(sel);
        if (t >= 5'(LOG_DEPTH)) begin
            t = t - 5'(LOG_DEPTH);
        end
        return t[3:0];
    endfunction

    // ======================================================================
    // time base
    logic [31:0] ms_cnt_ff, nxt_ms_cnt;
    logic [6:0]  ds_cnt_ff, nxt_ds_cnt;
    logic [47:0] ts_ff, nxt_ts;
    logic        ms_tick, ds_tick;

    always_comb begin
        ms_tick    = ms_cnt_ff == MS_CYCLES - 1;
        ds_tick    = ms_tick && ds_cnt_ff == 7'(DS_MS - 1);
        nxt_ms_cnt = ms_tick ? 32'h0000_0000 : ms_cnt_ff + 32'h0000_0001;
        nxt_ds_cnt = ds_tick ? 7'h00 : (ms_tick ? ds_cnt_ff + 7'h01 : ds_cnt_ff);
        nxt_ts     = ms_tick ? ts_ff + 48'h0000_0000_0001 : ts_ff;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ms_cnt_ff <= 32'h0000_0000;
            ds_cnt_ff <= 7'h00;
            ts_ff     <= 48'h0000_0000_0000;
        end else begin
            ms_cnt_ff <= nxt_ms_cnt;
            ds_cnt_ff <= nxt_ds_cnt;
            ts_ff     <= nxt_ts;
        end
    end

    // ======================================================================
    // settings store
    fsg_cfg_t    cfg_ff, nxt_cfg;
    logic        en_ff, nxt_en;
    logic [5:0]  ists_ff, nxt_ists, imsk_ff, nxt_imsk;
    logic [3:0]  sel_ff, nxt_sel;
    logic [5:0]  evt_ff;

    always_comb begin
        nxt_cfg  = cfg_ff;
        nxt_en   = en_ff;
        nxt_imsk = imsk_ff;
        nxt_sel  = sel_ff;
        if (wr) begin
            if (hit(addr, OFS_CTRL))     nxt_en               = wdata[0];
            if (hit(addr, OFS_HOT_LIM))  nxt_cfg.hot_limit    = wdata[9:0];
            if (hit(addr, OFS_STALL_C))  nxt_cfg.stall_cold   = wdata[12:0];
            if (hit(addr, OFS_STALL_H))  nxt_cfg.stall_hot    = wdata[12:0];
            if (hit(addr, OFS_STARTS_C)) nxt_cfg.starts_cold  = wdata[6:0];
            if (hit(addr, OFS_STARTS_H)) nxt_cfg.starts_hot   = wdata[6:0];
            if (hit(addr, OFS_WINDOW))   nxt_cfg.window_h     = wdata[6:0];
            if (hit(addr, OFS_MIN_INT))  nxt_cfg.min_interval = wdata[12:0];
            if (hit(addr, OFS_IRQ_MSK))  nxt_imsk             = wdata[5:0];
            if (hit(addr, OFS_LOG_SEL) && wdata[3:0] < 4'(LOG_DEPTH)) nxt_sel = wdata[3:0];
        end
        // new events win over a same-cycle clear
        nxt_ists = ists_ff;
        if (wr && hit(addr, OFS_IRQ_STS)) begin
            nxt_ists = ists_ff & ~wdata[5:0];
        end
        nxt_ists = nxt_ists | evt_ff;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_ff  <= '{RST_HOT_LIM, RST_STALL_C, RST_STALL_H, RST_STARTS_C,
                         RST_STARTS_H, RST_WINDOW, RST_MIN_INT};
            en_ff   <= RST_ENABLE;
            ists_ff <= 6'h00;
            imsk_ff <= 6'h00;
            sel_ff  <= 4'h0;
        end else begin
            cfg_ff  <= nxt_cfg;
            en_ff   <= nxt_en;
            ists_ff <= nxt_ists;
            imsk_ff <= nxt_imsk;
            sel_ff  <= nxt_sel;
        end
    end

    assign motor_cfg = cfg_ff;
    assign irq       = |(ists_ff & imsk_ff);

    // ======================================================================
    // start stress counter
    logic        hot;
    logic [12:0] stall, stall_cold_eff;
    logic [6:0]  allowed;
    logic [22:0] win_ds;
    logic [35:0] unit;
    logic [19:0] step;
    logic        start_pulse;
    logic        mst_q_ff;
    logic [43:0] cnt_ff, nxt_cnt, used_floor;
    logic [7:0]  used_ff, nxt_used;
    logic [23:0] since_ff, nxt_since, inh_ds_ff, nxt_inh_ds;
    logic        seen_ff, nxt_seen, int_inh_ff, nxt_int_inh;

    always_comb begin
        hot            = thermal_active && (theta_pm > cfg_ff.hot_limit);
        stall_cold_eff = (cfg_ff.stall_cold == 13'h0000) ? cfg_ff.stall_hot
                                                         : cfg_ff.stall_cold;
        stall          = hot ? cfg_ff.stall_hot : stall_cold_eff;
        allowed        = hot ? cfg_ff.starts_hot : cfg_ff.starts_cold;
        // widen before multiplying: long windows and stall times overflow the operand widths
        win_ds         = 23'(cfg_ff.window_h) * 23'(HOUR_DS);
        unit           = 36'(stall) * 36'(win_ds);
        step           = 20'(stall) * 20'(allowed);
        start_pulse    = motor_start_detected && !mst_q_ff;
        used_floor     = (used_ff == 8'h00) ? 44'h000_0000_0000
                                            : 44'(used_ff - 8'h01) * 44'(unit);
        // scaled by window: one start adds stall*window, each 0.1 s drains stall*allowed
        nxt_cnt = cnt_ff;
        if (start_pulse) begin
            nxt_cnt = cnt_ff + 44'(unit);
        end else if (ds_tick) begin
            nxt_cnt = (cnt_ff > 44'(step)) ? cnt_ff - 44'(step) : 44'h000_0000_0000;
        end
        nxt_used = used_ff;
        if (start_pulse) begin
            nxt_used = (used_ff == 8'hFF) ? used_ff : used_ff + 8'h01;
        end else if (used_ff != 8'h00 && cnt_ff <= used_floor) begin
            nxt_used = used_ff - 8'h01;
        end
        nxt_since = since_ff;
        if (start_pulse) begin
            nxt_since = 24'h00_0000;
        end else if (ds_tick && since_ff != 24'hFF_FFFF) begin
            nxt_since = since_ff + 24'h00_0001;
        end
        nxt_seen    = seen_ff || start_pulse;
        nxt_int_inh = int_inh_ff;
        if (start_pulse && seen_ff && since_ff < 24'(cfg_ff.min_interval)) begin
            nxt_int_inh = 1'b1;
        end else if (!start_pulse && since_ff >= 24'(cfg_ff.min_interval)) begin
            nxt_int_inh = 1'b0;
        end
        nxt_inh_ds = inh_ds_ff;
        if (!inhibit) begin
            nxt_inh_ds = 24'h00_0000;
        end else if (ds_tick && inh_ds_ff != 24'hFF_FFFF) begin
            nxt_inh_ds = inh_ds_ff + 24'h00_0001;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mst_q_ff   <= 1'b0;
            cnt_ff     <= 44'h000_0000_0000;
            used_ff    <= 8'h00;
            since_ff   <= 24'hFF_FFFF;
            seen_ff    <= 1'b0;
            int_inh_ff <= 1'b0;
            inh_ds_ff  <= 24'h00_0000;
        end else begin
            mst_q_ff   <= motor_start_detected;
            cnt_ff     <= nxt_cnt;
            used_ff    <= nxt_used;
            since_ff   <= nxt_since;
            seen_ff    <= nxt_seen;
            int_inh_ff <= nxt_int_inh;
            inh_ds_ff  <= nxt_inh_ds;
        end
    end

    // ======================================================================
    // outputs and events
    logic [2:0] out_ff, nxt_out;
    logic [5:0] nxt_evt;
    logic       cnt_inh;

    always_comb begin
        cnt_inh    = 8'(allowed) <= used_ff;
        nxt_out[0] = en_ff && !block_in && !cnt_inh && !int_inh_ff
                     && (8'(allowed) == used_ff + 8'h01);
        nxt_out[1] = en_ff && !block_in && (cnt_inh || int_inh_ff);
        nxt_out[2] = en_ff && block_in;
    end

    // ON in the even bit, OFF in the odd bit of each pair
    for (genvar g = 0; g < 3; g++) begin : g_edge
        assign nxt_evt[2*g]   =  nxt_out[g] && !out_ff[g];
        assign nxt_evt[2*g+1] = !nxt_out[g] &&  out_ff[g];
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_ff <= 3'b000;
            evt_ff <= 6'h00;
        end else begin
            out_ff <= nxt_out;
            evt_ff <= nxt_evt;
        end
    end

    assign alarm                   = out_ff[0];
    assign inhibit                 = out_ff[1];
    assign blocked                 = out_ff[2];
    assign start_guard_event_block = evt_ff;
    always_comb begin
        if (blocked)      condition = FSG_COND_BLOCKED;
        else if (inhibit) condition = FSG_COND_TRIP;
        else if (alarm)   condition = FSG_COND_START;
        else              condition = FSG_COND_NORMAL;
    end

    // ======================================================================
    // event log: simultaneous events queue up, one record per cycle
    logic [5:0] pend_ff, nxt_pend, grant;
    logic [2:0] gidx;
    logic [3:0] wptr_ff, nxt_wptr;
    logic [3:0] fill_ff, nxt_fill;
    fsg_rec_t   rec, log_q;

    always_comb begin
        grant = pend_ff & (~pend_ff + 6'h01);
        gidx  = 3'h0;
        for (int i = NUM_EVT - 1; i >= 0; i--) begin
            if (grant[i]) gidx = 3'(i);
        end
        nxt_pend = (pend_ff & ~grant) | evt_ff;
        rec      = '{ts_ff, gidx, used_ff, inh_ds_ff, since_ff};
        nxt_wptr = wptr_ff;
        nxt_fill = fill_ff;
        if (|pend_ff) begin
            nxt_wptr = (wptr_ff == 4'(LOG_DEPTH - 1)) ? 4'h0 : wptr_ff + 4'h1;
            nxt_fill = (fill_ff == 4'(LOG_DEPTH)) ? fill_ff : fill_ff + 4'h1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pend_ff <= 6'h00;
            wptr_ff <= 4'h0;
            fill_ff <= 4'h0;
        end else begin
            pend_ff <= nxt_pend;
            wptr_ff <= nxt_wptr;
            fill_ff <= nxt_fill;
        end
    end

    fsg_log_mem u_log (
        .clk   (clk),
        .we    (|pend_ff),
        .waddr (wptr_ff),
        .wdata (rec),
        .raddr (log_phys(wptr_ff, sel_ff)),
        .rdata (log_q)
    );

    // ======================================================================
    // register read
    logic [31:0] rreg_ff, nxt_rreg;
    logic [7:0]  raddr_ff;
    logic        rlog_ff, nxt_rlog;
    logic [31:0] log_word;

    always_comb begin
        nxt_rreg = 32'h0000_0000;
        nxt_rlog = 1'b0;
        if (rd) begin
            unique case (addr)
                OFS_CTRL:     nxt_rreg = {31'h0000_0000, en_ff};
                OFS_HOT_LIM:  nxt_rreg = 32'(cfg_ff.hot_limit);
                OFS_STALL_C:  nxt_rreg = 32'(cfg_ff.stall_cold);
                OFS_STALL_H:  nxt_rreg = 32'(cfg_ff.stall_hot);
                OFS_STARTS_C: nxt_rreg = 32'(cfg_ff.starts_cold);
                OFS_STARTS_H: nxt_rreg = 32'(cfg_ff.starts_hot);
                OFS_WINDOW:   nxt_rreg = 32'(cfg_ff.window_h);
                OFS_MIN_INT:  nxt_rreg = 32'(cfg_ff.min_interval);
                OFS_STATUS:   nxt_rreg = {16'h0000, used_ff, 2'b00, hot, condition, out_ff};
                OFS_IRQ_STS:  nxt_rreg = 32'(ists_ff);
                OFS_IRQ_MSK:  nxt_rreg = 32'(imsk_ff);
                OFS_LOG_SEL:  nxt_rreg = {20'h0_0000, fill_ff, 4'h0, sel_ff};
                OFS_LOG_TSL, OFS_LOG_TSH, OFS_LOG_EVT, OFS_LOG_INH, OFS_LOG_SINCE:
                              nxt_rlog = sel_ff < fill_ff;
                default:      nxt_rreg = 32'h0000_0000;
            endcase
        end
        unique case (raddr_ff)
            OFS_LOG_TSL: log_word = log_q.ts_ms[31:0];
            OFS_LOG_TSH: log_word = {16'h0000, log_q.ts_ms[47:32]};
            OFS_LOG_EVT: log_word = {16'h0000, log_q.used, 5'h00, log_q.evt};
            OFS_LOG_INH: log_word = {8'h00, log_q.inh_ds};
            default:     log_word = {8'h00, log_q.since_ds};
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rreg_ff  <= 32'h0000_0000;
            raddr_ff <= 8'h00;
            rlog_ff  <= 1'b0;
        end else begin
            rreg_ff  <= nxt_rreg;
            raddr_ff <= addr;
            rlog_ff  <= nxt_rlog;
        end
    end

    assign rdata = rlog_ff ? log_word : rreg_ff;
endmodule
`default_nettype wire

// [fsg_top_assertions.sv]
// port checks of the start guard top
// assumes bind onto fsg_top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module fsg_top_assertions
    import fsg_pkg::*;
#(
    parameter int unsigned MS_CYCLES = MS_CYC_DEF
)(
    // clock and reset
    input wire logic       clk,
    input wire logic       rst,
    // inputs and outputs watched
    input wire logic       block_in,
    input wire logic       alarm,
    input wire logic       inhibit,
    input wire logic       blocked,
    input wire fsg_cond_t  condition,
    input wire logic [5:0] start_guard_event_block
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ======================================================================
    // event pulses
    sequence s_alarm_pulse;
        start_guard_event_block[0] ##1 !start_guard_event_block[0];
    endsequence
    a_alarm_on_event: assert property ($rose(alarm) |-> s_alarm_pulse)
        else $error("alarm rise without one-cycle event");
    a_alarm_off_event: assert property ($fell(alarm) |-> start_guard_event_block[1])
        else $error("alarm fall without event");
    a_inhibit_on_event: assert property ($rose(inhibit) |-> start_guard_event_block[2])
        else $error("inhibit rise without event");
    a_blocked_on_event: assert property (start_guard_event_block[4] |-> $rose(blocked))
        else $error("blocked event without rise");
    a_inhibit_off_event: assert property ($fell(inhibit) |-> start_guard_event_block[3])
        else $error("inhibit fall without event");
    a_blocked_off_event: assert property ($fell(blocked) |-> start_guard_event_block[5])
        else $error("blocked fall without event");
    // ======================================================================
    // output relations
    a_alarm_not_inh: assert property (alarm |-> !inhibit)
        else $error("alarm and inhibit together");
    a_blocked_quiet: assert property (blocked |-> !alarm && !inhibit)
        else $error("blocked with alarm or inhibit");
    a_block_needs_in: assert property (!block_in |=> !blocked)
        else $error("blocked without block input");
    a_cond_code: assert property (inhibit |-> condition == FSG_COND_TRIP)
        else $error("wrong condition while inhibited");
    a_cond_blocked: assert property (blocked |-> condition == FSG_COND_BLOCKED)
        else $error("wrong condition while blocked");
endmodule
bind fsg_top fsg_top_assertions #(.MS_CYCLES(MS_CYCLES)) fsg_top_assertions_inst (
    .clk(clk), .rst(rst), .block_in(block_in), .alarm(alarm), .inhibit(inhibit),
    .blocked(blocked), .condition(condition),
    .start_guard_event_block(start_guard_event_block));
`default_nettype wire

// [fsg_motor_model.sv]
// far side: motor status start level and thermal capacity
// assumes bench commands on clk
`timescale 1ns/1ps
`default_nettype none
module fsg_motor_model (
    // clock and reset
    input  wire logic  clk,
    input  wire logic  rst,
    // bench commands
    input  wire logic  start_cmd,
    input  wire logic  hot_cmd,
    input  wire logic  therm_on,
    // towards the guard
    output logic       motor_start_detected,
    output logic       thermal_active,
    output logic [9:0] theta_pm
);
    logic [2:0] cnt_ff;
    logic [2:0] nxt_cnt;
    // ======================================================================
    // start level held a few cycles, as a real detection would
    always_comb begin
        nxt_cnt = (cnt_ff != 3'h0) ? cnt_ff - 3'h1 : 3'h0;
        if (start_cmd) begin
            nxt_cnt = 3'h4;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_ff <= 3'h0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end
    assign motor_start_detected = (cnt_ff != 3'h0);
    assign thermal_active = therm_on;
    // one step above the default limit, or exactly on it
    assign theta_pm = hot_cmd ? 10'h2BD : 10'h2BC;
endmodule
`default_nettype wire

// [tb_frequent_start_guard.sv]
// self-checking bench of the frequent start guard
// assumes fsg_top, fsg_motor_model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module tb_frequent_start_guard
    import fsg_pkg::*;
;
    logic        clk, rst, wr, rd, block_in, start_cmd, hot_cmd, therm_on;
    logic        motor_start_detected, thermal_active, alarm, inhibit, blocked, irq;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata;
    logic [9:0]  theta_pm;
    logic [5:0]  start_guard_event_block;
    fsg_cond_t   condition;
    fsg_cfg_t    motor_cfg;
    int          mismatches, n_checks, i;
    logic [7:0]  ofs [7] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};
    logic [31:0] dfl [7] = '{32'h0000_02BC, 32'h0000_00C8, 32'h0000_0096,
        32'h0000_0003, 32'h0000_0002, 32'h0000_0001, 32'h0000_00C8};
    // short count so 0.1 s is 1000 cycles
    fsg_top #(.MS_CYCLES(10)) fsg_top_inst (.clk, .rst, .addr, .wdata, .wr, .rd,
        .rdata, .motor_start_detected, .block_in, .thermal_active, .theta_pm, .alarm,
        .inhibit, .blocked, .condition, .start_guard_event_block, .irq, .motor_cfg);
    fsg_motor_model fsg_motor_model_inst (.clk, .rst, .start_cmd, .hot_cmd,
        .therm_on, .motor_start_detected, .thermal_active, .theta_pm);
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ======================================================================
    // tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        chk(rdata & m, e);
    endtask
    task automatic motor_start(input int gap);
        @(posedge clk);
        start_cmd <= 1'b1;
        @(posedge clk);
        start_cmd <= 1'b0;
        repeat (gap) @(posedge clk);
    endtask
    task automatic do_reset();
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        mismatches++;
        $display("[FAIL] %0t run too long", $time);
        test_done();
    end
    // ======================================================================
    // scenarios
    initial begin
        {rst, wr, rd, block_in, start_cmd, hot_cmd, therm_on} = 7'h40;
        addr = 8'h00;
        wdata = 32'h0000_0000;
        do_reset();
        rd_chk(OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
        for (i = 0; i < 7; i++) begin
            rd_chk(ofs[i], 32'hFFFF_FFFF, dfl[i]);
        end
        rd_chk(8'h44, 32'hFFFF_FFFF, 32'h0000_0000);
        wr_reg(OFS_HOT_LIM, 32'h0000_01F4);
        repeat (2) @(posedge clk);
        chk({22'h0, motor_cfg.hot_limit}, 32'h0000_01F4);
        $display("test reset values done");
        wr_reg(OFS_MIN_INT, 32'h0000_0001);
        wr_reg(OFS_IRQ_MSK, 32'h0000_003F);
        wr_reg(OFS_CTRL, 32'h0000_0001);
        motor_start(1200);
        rd_chk(OFS_STATUS, 32'h0000_FFFF, 32'h0000_0100);
        chk({31'h0, irq}, 32'h0000_0000);
        motor_start(1200);
        rd_chk(OFS_STATUS, 32'h0000_FFFF, 32'h0000_0209);
        motor_start(1200);
        rd_chk(OFS_STATUS, 32'h0000_FFFF, 32'h0000_0312);
        rd_chk(OFS_IRQ_STS, 32'h0000_003F, 32'h0000_0007);
        chk({31'h0, irq}, 32'h0000_0001);
        rd_chk(OFS_LOG_SEL, 32'h0000_0F0F, 32'h0000_0300);
        rd_chk(OFS_LOG_EVT, 32'h0000_FF07, 32'h0000_0302);
        wr_reg(OFS_LOG_SEL, 32'h0000_000C);
        rd_chk(OFS_LOG_SEL, 32'h0000_000F, 32'h0000_0000);
        wr_reg(OFS_IRQ_STS, 32'h0000_0007);
        wr_reg(OFS_IRQ_MSK, 32'h0000_0000);
        #1;
        chk({31'h0, irq}, 32'h0000_0000);
        block_in <= 1'b1;
        repeat (5) @(posedge clk);
        rd_chk(OFS_STATUS, 32'h0000_FFFF, 32'h0000_031C);
        rd_chk(OFS_IRQ_STS, 32'h0000_003F, 32'h0000_0018);
        chk({31'h0, irq}, 32'h0000_0000);
        block_in <= 1'b0;
        repeat (5) @(posedge clk);
        rd_chk(OFS_STATUS, 32'h0000_FFFF, 32'h0000_0312);
        $display("test cold starts done");
        do_reset();
        wr_reg(OFS_CTRL, 32'h0000_0001);
        therm_on <= 1'b1;
        repeat (3) @(posedge clk);
        rd_chk(OFS_STATUS, 32'h0000_0020, 32'h0000_0000);
        hot_cmd <= 1'b1;
        motor_start(20);
        rd_chk(OFS_STATUS, 32'h0000_FFFF, 32'h0000_0129);
        therm_on <= 1'b0;
        repeat (3) @(posedge clk);
        rd_chk(OFS_STATUS, 32'h0000_FFFF, 32'h0000_0100);
        motor_start(20);
        rd_chk(OFS_STATUS, 32'h0000_FFFF, 32'h0000_0212);
        $display("test hot and interval done");
        test_done();
    end
endmodule
`default_nettype wire
